// ===== pkg/lsd_pkg.sv
// Purpose: shared constants of the led sink control core
// Assumes: 50 MHz core clock, AXI4-Lite register access
// Notes: register offsets are byte addresses of aligned 32-bit words
package lsd_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int PWM_STEP_NS = 40;
	localparam int PWM_STEP_CYC = (PWM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GRP_STEP_NS = 20480;
	localparam int GRP_STEP_CYC = (GRP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// group ticks per blink phase step for a period value of zero
	localparam int BLINK_TICKS = 8;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_SECOND_MODE_REGISTER = 8'h00;
	localparam logic [7:0] OFS_GRP_DUTY = 8'h04;
	localparam logic [7:0] OFS_GRP_PERIOD = 8'h08;
	localparam logic [7:0] OFS_CHAN_EN = 8'h0C;
	localparam logic [7:0] OFS_EFLAG_LO = 8'h10;
	localparam logic [7:0] OFS_EFLAG_HI = 8'h14;
	localparam logic [7:0] OFS_BRIGHT = 8'h40;
	localparam logic [7:0] OFS_BRIGHT_END = 8'h7C;
	// second_mode_register fields
	localparam int SECOND_MODE_REGISTER_OT_CLR_BIT = 7;
	localparam int SECOND_MODE_REGISTER_BLINK_BIT = 5;
	localparam logic [7:0] SECOND_MODE_REGISTER_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] CHAN_EN_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------------------------------
	// soft reset call on the serial link
	// ----------------------------------------------------------------
	localparam logic [7:0] SOFT_RESET_CALL_ADDR = 8'hD6;
	localparam logic [7:0] SOFT_RESET_CALL_BYTE1 = 8'hA5;
	localparam logic [7:0] SOFT_RESET_CALL_BYTE2 = 8'h5A;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [2:0] {
		SR_IDLE = 3'b000,
		SR_ADDR = 3'b001,
		SR_BYTE1 = 3'b010,
		SR_BYTE2 = 3'b011,
		SR_ARMED = 3'b100
	} lsd_sr_state_t;
endpackage

// ===== hdl/lsd_core.sv
// Purpose: control core of a 16-channel led sink driver
// Assumes: ref_clk 50 MHz; serial link lines and sensors are asynchronous
// Notes: soft reset call decoder only; the rest of the link is elsewhere
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module lsd_core (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial link
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// pins and sensors
	input wire logic reset_pin_n,
	input wire logic glob_ot_trip,
	input wire logic [15:0] chan_ot_trip,
	input wire logic [15:0] open_load_low,
	// outputs
	output logic [15:0] led_drive,
	output logic standby
);
	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [35:0] in_s1_r, in_s2_r;
	logic scl_s, sda_s, ext_rst_s, glob_s;
	logic [15:0] chan_s, open_s;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			// link lines start at their idle high level
			in_s1_r <= 36'h0_0000_0003;
			in_s2_r <= 36'h0_0000_0003;
		end else begin
			in_s1_r <= {open_load_low, chan_ot_trip, glob_ot_trip,
				~reset_pin_n, sda_in, scl_in};
			in_s2_r <= in_s1_r;
		end
	end
	assign scl_s = in_s2_r[0];
	assign sda_s = in_s2_r[1];
	assign ext_rst_s = in_s2_r[2];
	assign glob_s = in_s2_r[3];
	assign chan_s = in_s2_r[19:4];
	assign open_s = in_s2_r[35:20];

	// internal reset: power-on, pin held low, or accepted soft reset call
	logic soft_reset_call_r, rst_int;
	assign rst_int = reset | ext_rst_s | soft_reset_call_r;

	// ----------------------------------------------------------------
	// soft reset call decoder
	// ----------------------------------------------------------------
	logic scl_q_r, sda_q_r, scl_rise, scl_fall, start_c, stop_c;
	lsd_pkg::lsd_sr_state_t sr_state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic in_ack_r, ack_r, byte_ok;

	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_s;
			sda_q_r <= sda_s;
		end
	end
	assign scl_rise = scl_s & ~scl_q_r;
	assign scl_fall = ~scl_s & scl_q_r;
	assign start_c = scl_s & scl_q_r & sda_q_r & ~sda_s;
	assign stop_c = scl_s & scl_q_r & ~sda_q_r & sda_s;

	always_comb begin
		case (sr_state_r)
		lsd_pkg::SR_ADDR: byte_ok = shift_r == lsd_pkg::SOFT_RESET_CALL_ADDR;
		lsd_pkg::SR_BYTE1: byte_ok = shift_r == lsd_pkg::SOFT_RESET_CALL_BYTE1;
		lsd_pkg::SR_BYTE2: byte_ok = shift_r == lsd_pkg::SOFT_RESET_CALL_BYTE2;
		default: byte_ok = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			sr_state_r <= lsd_pkg::SR_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			in_ack_r <= 1'b0;
			ack_r <= 1'b0;
			soft_reset_call_r <= 1'b0;
		end else begin
			soft_reset_call_r <= 1'b0;
			if (start_c) begin
				sr_state_r <= lsd_pkg::SR_ADDR;
				bit_cnt_r <= 4'h0;
				in_ack_r <= 1'b0;
				ack_r <= 1'b0;
			end else if (stop_c) begin
				soft_reset_call_r <= sr_state_r == lsd_pkg::SR_ARMED;
				sr_state_r <= lsd_pkg::SR_IDLE;
				in_ack_r <= 1'b0;
				ack_r <= 1'b0;
			end else if (sr_state_r != lsd_pkg::SR_IDLE) begin
				if (scl_rise && bit_cnt_r != lsd_pkg::BITS_PER_BYTE) begin
					shift_r <= {shift_r[6:0], sda_s};
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end else if (scl_fall && in_ack_r) begin
					in_ack_r <= 1'b0;
					ack_r <= 1'b0;
					bit_cnt_r <= 4'h0;
					if (!ack_r && sr_state_r != lsd_pkg::SR_ARMED) begin
						sr_state_r <= lsd_pkg::SR_IDLE;
					end
				end else if (scl_fall && bit_cnt_r == lsd_pkg::BITS_PER_BYTE) begin
					in_ack_r <= 1'b1;
					ack_r <= byte_ok;
					if (byte_ok) begin
						case (sr_state_r)
						lsd_pkg::SR_ADDR: sr_state_r <= lsd_pkg::SR_BYTE1;
						lsd_pkg::SR_BYTE1: sr_state_r <= lsd_pkg::SR_BYTE2;
						default: sr_state_r <= lsd_pkg::SR_ARMED;
						endcase
					end
				end
			end
		end
	end
	assign sda_out = 1'b0;
	assign sda_oe = ack_r;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	logic [7:0] second_mode_register_r, grp_duty_r, grp_period_r;
	logic [15:0] chan_en_r, status_r;
	logic [7:0] bright_r [16];
	logic wr_go, rd_go, wr_map, wr_bright;
	logic [3:0] wr_idx, rd_idx;

	assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
	assign wr_idx = s_axi_awaddr[5:2];
	assign rd_idx = s_axi_araddr[5:2];
	assign wr_bright = s_axi_awaddr >= lsd_pkg::OFS_BRIGHT &&
		s_axi_awaddr <= lsd_pkg::OFS_BRIGHT_END;

	always_comb begin
		if (s_axi_awaddr[1:0] != 2'h0) begin
			wr_map = 1'b0;
		end else if (s_axi_awaddr == lsd_pkg::OFS_SECOND_MODE_REGISTER ||
			s_axi_awaddr == lsd_pkg::OFS_GRP_DUTY ||
			s_axi_awaddr == lsd_pkg::OFS_GRP_PERIOD ||
			s_axi_awaddr == lsd_pkg::OFS_CHAN_EN ||
			s_axi_awaddr == lsd_pkg::OFS_EFLAG_LO ||
			s_axi_awaddr == lsd_pkg::OFS_EFLAG_HI || wr_bright) begin
			wr_map = 1'b1;
		end else begin
			wr_map = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			second_mode_register_r <= lsd_pkg::SECOND_MODE_REGISTER_RST;
			grp_duty_r <= lsd_pkg::BYTE_RST;
			grp_period_r <= lsd_pkg::BYTE_RST;
			chan_en_r <= lsd_pkg::CHAN_EN_RST;
		end else if (wr_go && s_axi_awaddr[1:0] == 2'h0) begin
			if (s_axi_awaddr == lsd_pkg::OFS_SECOND_MODE_REGISTER && s_axi_wstrb[0]) begin
				second_mode_register_r <= s_axi_wdata[7:0];
			end else if (s_axi_awaddr == lsd_pkg::OFS_GRP_DUTY &&
				s_axi_wstrb[0]) begin
				grp_duty_r <= s_axi_wdata[7:0];
			end else if (s_axi_awaddr == lsd_pkg::OFS_GRP_PERIOD &&
				s_axi_wstrb[0]) begin
				grp_period_r <= s_axi_wdata[7:0];
			end else if (s_axi_awaddr == lsd_pkg::OFS_CHAN_EN) begin
				if (s_axi_wstrb[0]) chan_en_r[7:0] <= s_axi_wdata[7:0];
				if (s_axi_wstrb[1]) chan_en_r[15:8] <= s_axi_wdata[15:8];
			end
		end
	end

	generate
		for (genvar i = 0; i < 16; i++) begin : g_bright
			always_ff @(posedge ref_clk) begin
				if (rst_int) begin
					bright_r[i] <= lsd_pkg::BYTE_RST;
				end else if (wr_go && wr_bright && wr_idx == 4'(i) &&
					s_axi_awaddr[1:0] == 2'h0 && s_axi_wstrb[0]) begin
					bright_r[i] <= s_axi_wdata[7:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= lsd_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_map ? lsd_pkg::RESP_OKAY : lsd_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= lsd_pkg::RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= lsd_pkg::RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			if (s_axi_araddr[1:0] != 2'h0) begin
				s_axi_rresp <= lsd_pkg::RESP_SLVERR;
			end else if (s_axi_araddr == lsd_pkg::OFS_SECOND_MODE_REGISTER) begin
				s_axi_rdata <= {24'h00_0000, second_mode_register_r};
			end else if (s_axi_araddr == lsd_pkg::OFS_GRP_DUTY) begin
				s_axi_rdata <= {24'h00_0000, grp_duty_r};
			end else if (s_axi_araddr == lsd_pkg::OFS_GRP_PERIOD) begin
				s_axi_rdata <= {24'h00_0000, grp_period_r};
			end else if (s_axi_araddr == lsd_pkg::OFS_CHAN_EN) begin
				s_axi_rdata <= {16'h0000, chan_en_r};
			end else if (s_axi_araddr == lsd_pkg::OFS_EFLAG_LO) begin
				s_axi_rdata <= {24'h00_0000, status_r[7:0]};
			end else if (s_axi_araddr == lsd_pkg::OFS_EFLAG_HI) begin
				s_axi_rdata <= {24'h00_0000, status_r[15:8]};
			end else if (s_axi_araddr >= lsd_pkg::OFS_BRIGHT &&
				s_axi_araddr <= lsd_pkg::OFS_BRIGHT_END) begin
				s_axi_rdata <= {24'h00_0000, bright_r[rd_idx]};
			end else begin
				s_axi_rresp <= lsd_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// brightness and group pwm timebases
	// ----------------------------------------------------------------
	logic [3:0] pwm_sub_r;
	logic [7:0] pwm_phase_r, grp_phase_r, blink_phase_r;
	logic [9:0] grp_cyc_r;
	logic [10:0] blink_pre_r;
	logic pwm_step, grp_tick, blink_step, blink_mode, grp_gate;

	assign pwm_step = pwm_sub_r == 4'(lsd_pkg::PWM_STEP_CYC - 1);
	assign grp_tick = grp_cyc_r == 10'(lsd_pkg::GRP_STEP_CYC - 1);
	assign blink_step = grp_tick && blink_pre_r ==
		{grp_period_r, 3'(lsd_pkg::BLINK_TICKS - 1)};
	assign blink_mode = second_mode_register_r[lsd_pkg::SECOND_MODE_REGISTER_BLINK_BIT];

	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			pwm_sub_r <= 4'h0;
			pwm_phase_r <= 8'h00;
		end else begin
			pwm_sub_r <= pwm_step ? 4'h0 : pwm_sub_r + 4'h1;
			if (pwm_step) pwm_phase_r <= pwm_phase_r + 8'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			grp_cyc_r <= 10'h000;
			grp_phase_r <= 8'h00;
			blink_pre_r <= 11'h000;
			blink_phase_r <= 8'h00;
		end else begin
			grp_cyc_r <= grp_tick ? 10'h000 : grp_cyc_r + 10'h001;
			if (grp_tick) grp_phase_r <= grp_phase_r + 8'h01;
			if (blink_step) begin
				blink_pre_r <= 11'h000;
				blink_phase_r <= blink_phase_r + 8'h01;
			end else if (grp_tick) begin
				blink_pre_r <= blink_pre_r + 11'h001;
			end
		end
	end

	// dimming passes 2M brightness periods per group period
	assign grp_gate = blink_mode ? (blink_phase_r < grp_duty_r) :
		(grp_phase_r < grp_duty_r);

	// ----------------------------------------------------------------
	// outputs and error status
	// ----------------------------------------------------------------
	logic [15:0] ot_err_r, pwm_on, unmod, open_fault, ot_set, led_nxt;
	logic ot_clr;

	assign ot_clr = second_mode_register_r[lsd_pkg::SECOND_MODE_REGISTER_OT_CLR_BIT];
	generate
		for (genvar i = 0; i < 16; i++) begin : g_chan
			assign pwm_on[i] = pwm_phase_r < bright_r[i];
			assign unmod[i] = bright_r[i] == 8'hFF &&
				grp_duty_r == 8'hFF && !blink_mode;
		end
	endgenerate
	assign open_fault = chan_en_r & unmod & open_s;
	assign ot_set = {16{glob_s}} | (chan_s & chan_en_r);
	assign led_nxt = chan_en_r & pwm_on & {16{grp_gate}} &
		~chan_s & ~{16{glob_s}};

	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			ot_err_r <= 16'h0000;
		end else if (ot_clr) begin
			ot_err_r <= 16'h0000;
		end else begin
			ot_err_r <= ot_err_r | ot_set;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			status_r <= 16'h0000;
			led_drive <= 16'h0000;
		end else begin
			// one is normal; off channels read zero as detection is impossible
			status_r <= chan_en_r & ~ot_err_r & ~ot_set & ~open_fault;
			led_drive <= led_nxt;
		end
	end
	assign standby = chan_en_r == 16'h0000;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	property p_glob_off;
		glob_s && !ext_rst_s |=> led_drive == 16'h0000 && status_r == 16'h0000;
	endproperty
	a_glob_off: assert property (p_glob_off) else $error("global trip left drive");

	property p_chan_off;
		!ext_rst_s |=> (led_drive & $past(chan_s)) == 16'h0000;
	endproperty
	a_chan_off: assert property (p_chan_off) else $error("hot channel driven");

	property p_persist;
		$fell(glob_s) && !ot_clr && !ext_rst_s && !soft_reset_call_r |=> ##1
			status_r == 16'h0000;
	endproperty
	a_persist: assert property (p_persist) else $error("fault not held");

	property p_off_no_fault;
		!glob_s && !ot_clr && !rst_int |=>
			((ot_err_r & ~$past(ot_err_r)) & ~$past(chan_en_r)) == 16'h0000;
	endproperty
	a_off_no_fault: assert property (p_off_no_fault) else $error("off fault");

	property p_open_flag;
		(open_fault != 16'h0000) && !rst_int |=>
			(status_r & $past(open_fault)) == 16'h0000;
	endproperty
	a_open_flag: assert property (p_open_flag) else $error("open not flagged");

	property p_clear;
		ot_clr && !glob_s |=> ##1 ot_err_r == 16'h0000;
	endproperty
	a_clear: assert property (p_clear) else $error("clear ignored");

	property p_bad_addr;
		sr_state_r == lsd_pkg::SR_ADDR && scl_fall && !in_ack_r &&
			bit_cnt_r == lsd_pkg::BITS_PER_BYTE &&
			shift_r != lsd_pkg::SOFT_RESET_CALL_ADDR && !start_c && !stop_c |=> !sda_oe;
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("acked bad address");

	property p_no_third;
		sr_state_r == lsd_pkg::SR_ARMED && $rose(sda_oe) |->
			$past(sr_state_r) == lsd_pkg::SR_BYTE2;
	endproperty
	a_no_third: assert property (p_no_third) else $error("third byte acked");

	property p_soft_reset_call;
		stop_c && sr_state_r == lsd_pkg::SR_ARMED |=> soft_reset_call_r ##1
			(chan_en_r == 16'h0000 && second_mode_register_r == lsd_pkg::SECOND_MODE_REGISTER_RST);
	endproperty
	a_soft_reset_call: assert property (p_soft_reset_call) else $error("soft reset missed");

	property p_no_soft_reset_call;
		soft_reset_call_r |-> $past(sr_state_r) == lsd_pkg::SR_ARMED;
	endproperty
	a_no_soft_reset_call: assert property (p_no_soft_reset_call) else $error("stray soft reset");

	property p_pin_rst;
		ext_rst_s |=> standby && led_drive == 16'h0000;
	endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("pin reset ignored");

	c_soft_reset_call: cover property (soft_reset_call_r);
	c_glob: cover property (glob_s && chan_en_r != 16'h0000);
	c_blink: cover property (blink_mode && blink_step);
	c_write: cover property (wr_go && wr_map);
endmodule
`default_nettype wire

// ===== tb/lsd_i2c_host.sv
// Purpose: serial link host that issues soft reset calls
// Assumes: both lines pulled up; 160 ns link clock period
// Notes: timed apart from ref_clk so the core sees an unrelated phase
`timescale 1ns/10ps
`default_nettype none
module lsd_i2c_host (
	// link lines
	input wire logic sda_line,
	output logic scl,
	output logic sda_drv
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// start, also usable as a repeated start from a low clock
	task automatic start();
		#7;
		sda_drv = 1'b1;
		#40;
		scl = 1'b1;
		#80;
		sda_drv = 1'b0;
		#80;
		scl = 1'b0;
	endtask
	// clock then stands still high until the next frame
	task automatic stop();
		#20;
		sda_drv = 1'b0;
		#80;
		scl = 1'b1;
		#80;
		sda_drv = 1'b1;
		#80;
	endtask
	// msb first; the ninth clock leaves the line to the device
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= -1; i--) begin
			#20;
			sda_drv = (i < 0) ? 1'b1 : b[i];
			#80;
			scl = 1'b1;
			#30;
			ack = ~sda_line;
			#30;
			scl = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ===== tb/lsd_core_bench.sv
// Purpose: self-checking bench of the led sink control core
// Assumes: 50 MHz ref_clk; link host model on the serial lines
// Notes: pwm duty is counted over one full pwm period
`timescale 1ns/10ps
`default_nettype none
module lsd_core_bench;
	// --------
	// signals
	// --------
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic reset_pin_n = 1'b1;
	logic glob_ot = 1'b0;
	logic [15:0] chan_ot = 16'h0000;
	logic [15:0] open_ld = 16'h0000;
	logic awready, wready, bvalid, arready, rvalid;
	logic sda_out, sda_oe, standby, scl, sda_drv;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] led_drive;
	logic [7:0] br [16];
	int hi [16];
	int n_fail = 0;
	int n_checks = 0;
	int seed = 32'h387EB7E4;
	wire logic sda_line;
	// a released line floats to the pull-up level
	assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
	always #10 ref_clk = ~ref_clk;
	lsd_core DUT (
		.ref_clk(ref_clk), .reset(reset),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe),
		.reset_pin_n(reset_pin_n), .glob_ot_trip(glob_ot),
		.chan_ot_trip(chan_ot), .open_load_low(open_ld),
		.led_drive(led_drive), .standby(standby)
	);
	lsd_i2c_host host (.sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
	// --------
	// helpers
	// --------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	function automatic logic rdy(input int s);
		case (s)
			0: return awready & wready;
			1: return bvalid;
			2: return arready;
			default: return rvalid;
		endcase
	endfunction
	// bounded wait for a handshake sampled at the rising edge
	task automatic wait_on(input int s);
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
			if (k > 200) begin
				n_fail++;
				complete_run();
			end
		end while (rdy(s) !== 1'b1);
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		wait_on(0);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		wait_on(1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		wait_on(2);
		arvalid <= 1'b0;
		rready <= 1'b1;
		wait_on(3);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axw(a, d, r);
		check("bresp", {30'h0, r}, {30'h0, lsd_pkg::RESP_OKAY});
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		check("rdata", d, want);
		check("rresp", {30'h0, r}, {30'h0, lsd_pkg::RESP_OKAY});
	endtask
	// drive-high cycles of every channel over one pwm period
	task automatic measure();
		for (int c = 0; c < 16; c++)
			hi[c] = 0;
		repeat (256 * lsd_pkg::PWM_STEP_CYC) begin
			@(posedge ref_clk);
			for (int c = 0; c < 16; c++)
				hi[c] += led_drive[c];
		end
	endtask
	function automatic int exp_hi(input logic [7:0] n);
		return n * lsd_pkg::PWM_STEP_CYC;
	endfunction
	function automatic logic [31:0] exp_flags(input logic [7:0] bad);
		return {24'h0, ~bad};
	endfunction
	// one reset call attempt; bit i of got is the ack of byte i
	task automatic swr(input logic [31:0] b, input int nb,
		input logic [3:0] want);
		logic a;
		logic [3:0] got;
		got = 4'h0;
		host.start();
		for (int i = 0; i < nb; i++) begin
			host.send(b[31 - 8 * i -: 8], a);
			got[i] = a;
		end
		host.stop();
		cyc(8);
		check("ack", {28'h0, got}, {28'h0, want});
	endtask
	// --------
	// sequence
	// --------
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		cyc(4);
		reset <= 1'b0;
		check("standby", standby, 1);
		check("led", led_drive, 0);
		check("sda_oe", sda_oe, 0);
		rdchk(lsd_pkg::OFS_SECOND_MODE_REGISTER, 0);
		rdchk(lsd_pkg::OFS_CHAN_EN, 0);
		rdchk(lsd_pkg::OFS_EFLAG_LO, 0);
		axr(8'h18, d, r);
		check("unmapped", {d[29:0], r}, {30'h0, lsd_pkg::RESP_SLVERR});
		axw(8'h06, 32'h0, r);
		check("misaligned", {30'h0, r}, {30'h0, lsd_pkg::RESP_SLVERR});
		wr(lsd_pkg::OFS_GRP_DUTY, 32'hFF);
		wr(lsd_pkg::OFS_CHAN_EN, 32'hFFFF_FFFF);
		check("standby", standby, 0);
		rdchk(lsd_pkg::OFS_CHAN_EN, 32'hFFFF);
		for (int c = 0; c < 16; c++) begin
			d = $random(seed);
			if (c < 2)
				d[7:0] = c ? 8'hFF : 8'h00;
			br[c] = d[7:0];
			wr(lsd_pkg::OFS_BRIGHT + 8'(4 * c), d);
			rdchk(lsd_pkg::OFS_BRIGHT + 8'(4 * c), {24'h0, br[c]});
		end
		measure();
		for (int c = 0; c < 16; c++)
			check("pwm high", hi[c], exp_hi(br[c]));
		for (int c = 0; c < 16; c++)
			wr(lsd_pkg::OFS_BRIGHT + 8'(4 * c), 32'hFF);
		cyc(8);
		rdchk(lsd_pkg::OFS_EFLAG_LO, exp_flags(8'h00));
		rdchk(lsd_pkg::OFS_EFLAG_HI, exp_flags(8'h00));
		open_ld <= 16'h0008;
		cyc(8);
		rdchk(lsd_pkg::OFS_EFLAG_LO, exp_flags(8'h08));
		wr(lsd_pkg::OFS_BRIGHT + 8'h0C, 32'h80);
		cyc(8);
		rdchk(lsd_pkg::OFS_EFLAG_LO, exp_flags(8'h00));
		open_ld <= 16'h0000;
		wr(lsd_pkg::OFS_BRIGHT + 8'h0C, 32'hFF);
		wr(lsd_pkg::OFS_CHAN_EN, 32'hFFBF);
		chan_ot <= 16'h0060;
		cyc(4);
		measure();
		check("tripped", hi[5], 0);
		check("neighbour", hi[4], exp_hi(8'hFF));
		chan_ot <= 16'h0000;
		cyc(8);
		wr(lsd_pkg::OFS_CHAN_EN, 32'hFFFF);
		cyc(8);
		rdchk(lsd_pkg::OFS_EFLAG_LO, exp_flags(8'h20));
		rdchk(lsd_pkg::OFS_EFLAG_HI, exp_flags(8'h00));
		measure();
		check("restart", hi[5], exp_hi(8'hFF));
		wr(lsd_pkg::OFS_SECOND_MODE_REGISTER, 32'h80);
		wr(lsd_pkg::OFS_SECOND_MODE_REGISTER, 32'h00);
		rdchk(lsd_pkg::OFS_EFLAG_LO, exp_flags(8'h00));
		glob_ot <= 1'b1;
		cyc(4);
		measure();
		for (int c = 0; c < 16; c++)
			check("global off", hi[c], 0);
		glob_ot <= 1'b0;
		cyc(8);
		rdchk(lsd_pkg::OFS_EFLAG_LO, exp_flags(8'hFF));
		rdchk(lsd_pkg::OFS_EFLAG_HI, exp_flags(8'hFF));
		measure();
		check("restart", hi[0], exp_hi(8'hFF));
		wr(lsd_pkg::OFS_SECOND_MODE_REGISTER, 32'h80);
		wr(lsd_pkg::OFS_SECOND_MODE_REGISTER, 32'h00);
		rdchk(lsd_pkg::OFS_EFLAG_HI, exp_flags(8'h00));
		wr(lsd_pkg::OFS_GRP_DUTY, 32'h00);
		cyc(4);
		measure();
		check("group dark", hi[0], 0);
		swr(32'hD700_0000, 1, 4'b0000);
		swr(32'hD6A4_0000, 2, 4'b0001);
		swr(32'hD6A5_5B00, 3, 4'b0011);
		swr(32'hD6A5_0000, 2, 4'b0011);
		rdchk(lsd_pkg::OFS_CHAN_EN, 32'hFFFF);
		swr(32'hD6A5_5A00, 4, 4'b0111);
		swr(32'hD6A5_5A00, 3, 4'b0111);
		rdchk(lsd_pkg::OFS_CHAN_EN, 0);
		check("standby", standby, 1);
		// timebases restarted by the soft reset: group phase known
		wr(lsd_pkg::OFS_GRP_DUTY, 32'h01);
		wr(lsd_pkg::OFS_CHAN_EN, 32'h0001);
		wr(lsd_pkg::OFS_BRIGHT, 32'hFF);
		cyc(1100);
		measure();
		check("dim M=1 gap", hi[0], 0);
		wr(lsd_pkg::OFS_SECOND_MODE_REGISTER, 32'h20);
		measure();
		check("blink on", hi[0], exp_hi(8'hFF));
		wr(lsd_pkg::OFS_SECOND_MODE_REGISTER, 32'h00);
		wr(lsd_pkg::OFS_CHAN_EN, 32'h00FF);
		reset_pin_n <= 1'b0;
		cyc(4);
		check("standby", standby, 1);
		reset_pin_n <= 1'b1;
		cyc(4);
		rdchk(lsd_pkg::OFS_CHAN_EN, 0);
		wr(lsd_pkg::OFS_CHAN_EN, 32'h0001);
		rdchk(lsd_pkg::OFS_CHAN_EN, 32'h0001);
		complete_run();
	end
endmodule
`default_nettype wire
